/* include/scaling_map.svh */
// register map, field positions, reset values and scaling constants
// assumes: included by bare name from the design files of the scaling block
`ifndef SCALING_MAP_SVH
`define SCALING_MAP_SVH

// register byte addresses
`define REG_CTRL 8'h00
`define REG_FMAX 8'h04
`define REG_RATED 8'h08
`define REG_ACC1 8'h0C
`define REG_DEC1 8'h10
`define REG_ACC2 8'h14
`define REG_DEC2 8'h18
`define REG_AI1_SCAN 8'h1C
`define REG_AI1_GAIN 8'h20
`define REG_AI1_BIAS 8'h24
`define REG_AI2_SCAN 8'h28
`define REG_AI2_GAIN 8'h2C
`define REG_AI2_BIAS 8'h30
`define REG_METER_GAIN 8'h34
`define REG_METER_BIAS 8'h38
`define REG_STATUS 8'h3C
`define REG_FREQ_BASE 8'h40
`define REG_ACC_BASE 8'h80
`define REG_DEC_BASE 8'hC0

// field positions inside bias and control registers
`define BIAS_SIGN_BIT 10
`define SLOPE_BIT 11
`define CTRL_MSB 8

// reset values
`define RST_FMAX 16'h1770
`define RST_RATED 16'h1770
`define RST_RAMP 16'h0064
`define RST_GAIN 11'h064
`define RST_SCAN 8'h01

// scaling constants
`define GAIN_UNITY 11'h064
`define BIAS_UNITY 10'h3E8
`define ADC_FULL 12'hFFF
`define LIVE_ZERO 12'h333
`define METER_FULL 12'hFA0
`define RAMP_MAX 16'hFFFF

// timing
`define CLK_KHZ 32'h61A8
`define SCAN_PERIOD_US 32'h7D0
`define US_PER_MS 32'h3E8

`endif

/* include/scaling_pkg.sv */
// types shared by the analog scaling and preset speed block
// assumes: nothing beyond a SystemVerilog compiler
package scaling_pkg;

    // meter output source codes
    typedef enum logic [2:0] {
        SRC_OUT_FREQ,
        SRC_FREQ_SET,
        SRC_OUT_VOLT,
        SRC_DC_BUS,
        SRC_OUT_CURR
    } meter_src_t;

    // control register layout
    typedef struct packed {
        meter_src_t meter_src;
        logic ramp_set;
        logic preset_mode;
        logic bias_target;
        logic ai2_func;
        logic [1:0] in_type;
    } ctrl_t;

    // gain, bias, bias sign and slope of one scaler
    typedef struct packed {
        logic neg_slope;
        logic neg_bias;
        logic [9:0] bias;
        logic [10:0] gain;
    } scale_cfg_t;

    // drive quantities offered to the meter
    typedef struct packed {
        logic [15:0] out_freq;
        logic [11:0] out_volt;
        logic [11:0] dc_bus;
        logic [11:0] out_curr;
    } sense_t;

endpackage : scaling_pkg

/* hw/gain_bias_scaler.sv */
// gain, signed bias, slope and clamp applied to one quantity
// assumes: value and full share the same unit; settings come from registers
`timescale 1ns/1ns
`include "scaling_map.svh"

module gain_bias_scaler (
    // operand and its full scale
    input wire logic [15:0] value,
    input wire logic [15:0] full,
    // scaling settings
    input wire scaling_pkg::scale_cfg_t cfg,
    // scaled result, 0 to full
    output logic [15:0] result
);
    logic [26:0] gained;
    logic [25:0] offset;
    logic signed [28:0] sum;
    logic [15:0] clipped;

    // gain in percent, bias in tenths of a percent of full
    always_comb begin
        gained = 27'((27'(value) * 27'(cfg.gain)) / 27'(`GAIN_UNITY));
        offset = 26'((26'(full) * 26'(cfg.bias)) / 26'(`BIAS_UNITY));
        if (cfg.neg_bias) begin
            sum = $signed({2'b00, gained}) - $signed({3'b000, offset});
        end else begin
            sum = $signed({2'b00, gained}) + $signed({3'b000, offset});
        end
        if (sum < 29'sh0) begin
            clipped = 16'h0000;
        end else if (sum > $signed({13'h0000, full})) begin
            clipped = full;
        end else begin
            clipped = sum[15:0];
        end
        result = cfg.neg_slope ? (full - clipped) : clipped;
    end

endmodule : gain_bias_scaler

/* hw/analog_ref_scaling_preset_speed.sv */
// analog reference scaling, meter output and preset speed table
// assumes: converter codes arrive unsynchronised; drive-side inputs share clk
`timescale 1ns/1ns
`include "scaling_map.svh"

module analog_ref_scaling_preset_speed #(
    parameter int unsigned TICK_CYCLES = `CLK_KHZ * `SCAN_PERIOD_US / `US_PER_MS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // converter codes of the two analog inputs
    input wire logic [11:0] analog_in_one,
    input wire logic [11:0] analog_in_two,
    // drive side inputs
    input wire logic [15:0] keypad_potentiometer,
    input wire logic [3:0] preset_sel,
    input wire scaling_pkg::sense_t sense,
    // drive side outputs, 0.01 Hz and 0.1 s units
    output logic [15:0] freq_cmd,
    output logic [15:0] pid_feedback,
    output logic [15:0] preset_freq,
    output logic [15:0] ramp_acc,
    output logic [15:0] ramp_dec,
    // meter converter code
    output logic [11:0] meter_out
);
    scaling_pkg::ctrl_t ctrl, next_ctrl;
    logic [15:0] fmax, next_fmax, rated, next_rated;
    logic [15:0] ramp_common [4];
    logic [15:0] next_ramp_common [4];
    logic [7:0] scan [2];
    logic [7:0] next_scan [2];
    scaling_pkg::scale_cfg_t cfg [3];
    scaling_pkg::scale_cfg_t next_cfg [3];
    logic [15:0] freq_tab [16];
    logic [15:0] acc_tab [16];
    logic [15:0] dec_tab [16];
    logic [15:0] next_freq_tab [16];
    logic [15:0] next_acc_tab [16];
    logic [15:0] next_dec_tab [16];
    logic [31:0] next_rdata;
    logic [1:0] scan_wr;
    logic aligned;
    logic [11:0] sync_meta [2];
    logic [11:0] sync_q [2];
    logic [15:0] tick_cnt, next_tick_cnt;
    logic tick, next_tick;
    logic [19:0] sum [2];
    logic [19:0] next_sum [2];
    logic [7:0] cnt [2];
    logic [7:0] next_cnt [2];
    logic [11:0] avg [2];
    logic [11:0] next_avg [2];
    logic [1:0] upd, next_upd;
    logic [7:0] scan_eff [2];
    logic [15:0] conv1, conv2, scaled1, scaled2, meter_norm, meter_scaled;
    logic [15:0] next_freq_cmd, next_pid, next_preset_freq, next_acc, next_dec;
    logic [11:0] next_meter;

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    // input code to frequency for full-span or live-zero range
    function automatic logic [15:0] to_freq(input logic [11:0] s, input logic live,
                                            input logic [15:0] top);
        logic [27:0] p;
        p = 28'h0000000;
        if (!live) begin
            p = (28'(s) * 28'(top)) / 28'(`ADC_FULL);
        end else if (s >= `LIVE_ZERO) begin
            p = (28'(s - `LIVE_ZERO) * 28'(top)) / 28'(`ADC_FULL - `LIVE_ZERO);
        end
        return p[15:0];
    endfunction : to_freq

    // quantity against its full scale, in meter codes
    function automatic logic [15:0] to_meter(input logic [15:0] q, input logic [15:0] top);
        logic [31:0] p;
        p = 32'h00000000;
        if (top != 16'h0000) begin
            p = (32'(q) * 32'(`METER_FULL)) / 32'(top);
        end
        if (p > 32'(`METER_FULL)) begin
            p = 32'(`METER_FULL);
        end
        return p[15:0];
    endfunction : to_meter

    // actual ramp time scaled by target over rated frequency
    function automatic logic [15:0] ramp_scale(input logic [15:0] t, input logic [15:0] f,
                                               input logic [15:0] r);
        logic [31:0] p;
        p = 32'(t);
        if (r != 16'h0000) begin
            p = (32'(t) * 32'(f)) / 32'(r);
        end
        if (p > 32'(`RAMP_MAX)) begin
            p = 32'(`RAMP_MAX);
        end
        return p[15:0];
    endfunction : ramp_scale

    // register writes and registered read data
    always_comb begin
        next_ctrl = ctrl;
        next_fmax = fmax;
        next_rated = rated;
        next_ramp_common = ramp_common;
        next_scan = scan;
        next_cfg = cfg;
        next_freq_tab = freq_tab;
        next_acc_tab = acc_tab;
        next_dec_tab = dec_tab;
        next_rdata = 32'h00000000;
        scan_wr = 2'b00;
        aligned = (addr[1:0] == 2'b00);
        if (wr && aligned) begin
            if (addr == `REG_CTRL) begin
                next_ctrl = scaling_pkg::ctrl_t'(wdata[`CTRL_MSB:0]);
            end else if (addr == `REG_FMAX) begin
                next_fmax = wdata[15:0];
            end else if (addr == `REG_RATED) begin
                next_rated = wdata[15:0];
            end else if (addr >= `REG_ACC1 && addr <= `REG_DEC2) begin
                next_ramp_common[2'(addr[4:2] - 3'h3)] = wdata[15:0];
            end else if (addr == `REG_AI1_SCAN) begin
                next_scan[0] = wdata[7:0];
                scan_wr[0] = 1'b1;
            end else if (addr == `REG_AI2_SCAN) begin
                next_scan[1] = wdata[7:0];
                scan_wr[1] = 1'b1;
            end else if (addr == `REG_AI1_GAIN) begin
                next_cfg[0].gain = wdata[10:0];
            end else if (addr == `REG_AI2_GAIN) begin
                next_cfg[1].gain = wdata[10:0];
            end else if (addr == `REG_METER_GAIN) begin
                next_cfg[2].gain = wdata[10:0];
            end else if (addr == `REG_AI1_BIAS) begin
                next_cfg[0] = {wdata[`SLOPE_BIT], wdata[`BIAS_SIGN_BIT], wdata[9:0], cfg[0].gain};
            end else if (addr == `REG_AI2_BIAS) begin
                next_cfg[1] = {wdata[`SLOPE_BIT], wdata[`BIAS_SIGN_BIT], wdata[9:0], cfg[1].gain};
            end else if (addr == `REG_METER_BIAS) begin
                next_cfg[2] = {wdata[`SLOPE_BIT], wdata[`BIAS_SIGN_BIT], wdata[9:0], cfg[2].gain};
            end else if (addr >= `REG_FREQ_BASE && addr < `REG_ACC_BASE) begin
                next_freq_tab[addr[5:2]] = wdata[15:0];
            end else if (addr >= `REG_ACC_BASE && addr < `REG_DEC_BASE) begin
                next_acc_tab[addr[5:2]] = wdata[15:0];
            end else if (addr >= `REG_DEC_BASE) begin
                next_dec_tab[addr[5:2]] = wdata[15:0];
            end
        end
        if (rd && aligned) begin
            if (addr == `REG_CTRL) begin
                next_rdata = 32'(ctrl);
            end else if (addr == `REG_FMAX) begin
                next_rdata = 32'(fmax);
            end else if (addr == `REG_RATED) begin
                next_rdata = 32'(rated);
            end else if (addr >= `REG_ACC1 && addr <= `REG_DEC2) begin
                next_rdata = 32'(ramp_common[2'(addr[4:2] - 3'h3)]);
            end else if (addr == `REG_AI1_SCAN) begin
                next_rdata = 32'(scan[0]);
            end else if (addr == `REG_AI2_SCAN) begin
                next_rdata = 32'(scan[1]);
            end else if (addr == `REG_AI1_GAIN) begin
                next_rdata = 32'(cfg[0].gain);
            end else if (addr == `REG_AI2_GAIN) begin
                next_rdata = 32'(cfg[1].gain);
            end else if (addr == `REG_METER_GAIN) begin
                next_rdata = 32'(cfg[2].gain);
            end else if (addr == `REG_AI1_BIAS) begin
                next_rdata = 32'(cfg[0][22:11]);
            end else if (addr == `REG_AI2_BIAS) begin
                next_rdata = 32'(cfg[1][22:11]);
            end else if (addr == `REG_METER_BIAS) begin
                next_rdata = 32'(cfg[2][22:11]);
            end else if (addr == `REG_STATUS) begin
                next_rdata = {8'h00, avg[1], avg[0]};
            end else if (addr >= `REG_FREQ_BASE && addr < `REG_ACC_BASE) begin
                next_rdata = 32'(freq_tab[addr[5:2]]);
            end else if (addr >= `REG_ACC_BASE && addr < `REG_DEC_BASE) begin
                next_rdata = 32'(acc_tab[addr[5:2]]);
            end else if (addr >= `REG_DEC_BASE) begin
                next_rdata = 32'(dec_tab[addr[5:2]]);
            end
        end
    end

    // register file storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
            fmax <= `RST_FMAX;
            rated <= `RST_RATED;
            ramp_common <= '{default: `RST_RAMP};
            scan <= '{default: `RST_SCAN};
            cfg <= '{default: '{1'b0, 1'b0, 10'h000, `RST_GAIN}};
            freq_tab <= '{default: 16'h0000};
            acc_tab <= '{default: `RST_RAMP};
            dec_tab <= '{default: `RST_RAMP};
            rdata <= 32'h00000000;
        end else begin
            ctrl <= next_ctrl;
            fmax <= next_fmax;
            rated <= next_rated;
            ramp_common <= next_ramp_common;
            scan <= next_scan;
            cfg <= next_cfg;
            freq_tab <= next_freq_tab;
            acc_tab <= next_acc_tab;
            dec_tab <= next_dec_tab;
            rdata <= next_rdata;
        end
    end

    // 2 ms tick and sample averaging of input one, and of input two outside bias mode
    always_comb begin
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt + 16'h0001;
        if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
            next_tick_cnt = 16'h0000;
            next_tick = 1'b1;
        end
        next_sum = sum;
        next_cnt = cnt;
        next_avg = avg;
        next_upd = 2'b00;
        for (int i = 0; i < 2; i++) begin
            scan_eff[i] = (scan[i] == 8'h00) ? 8'h01 : scan[i];
            if (scan_wr[i]) begin
                next_sum[i] = 20'h00000;
                next_cnt[i] = 8'h00;
            end else if (tick) begin
                if (cnt[i] + 8'h01 >= scan_eff[i]) begin
                    next_avg[i] = 12'((sum[i] + 20'(sync_q[i])) / 20'(cnt[i] + 8'h01));
                    next_sum[i] = 20'h00000;
                    next_cnt[i] = 8'h00;
                    next_upd[i] = 1'b1;
                end else begin
                    next_sum[i] = sum[i] + 20'(sync_q[i]);
                    next_cnt[i] = cnt[i] + 8'h01;
                end
            end
        end
        if (ctrl.ai2_func) begin
            next_avg[1] = sync_q[1];
        end
    end

    // synchronisers and sampling state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_meta <= '{default: 12'h000};
            sync_q <= '{default: 12'h000};
            tick_cnt <= 16'h0000;
            tick <= 1'b0;
            sum <= '{default: 20'h00000};
            cnt <= '{default: 8'h00};
            avg <= '{default: 12'h000};
            upd <= 2'b00;
        end else begin
            sync_meta[0] <= analog_in_one;
            sync_meta[1] <= analog_in_two;
            sync_q <= sync_meta;
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
            sum <= next_sum;
            cnt <= next_cnt;
            avg <= next_avg;
            upd <= next_upd;
        end
    end

    // input scalers and meter scaler
    gain_bias_scaler u_scale_one (.value(conv1), .full(fmax), .cfg(cfg[0]), .result(scaled1));
    gain_bias_scaler u_scale_two (.value(conv2), .full(fmax), .cfg(cfg[1]), .result(scaled2));
    gain_bias_scaler u_scale_meter (
        .value(meter_norm),
        .full(16'(`METER_FULL)),
        .cfg(cfg[2]),
        .result(meter_scaled)
    );

    // frequency command, feedback, meter and preset selection
    always_comb begin
        logic [16:0] biased;
        logic [15:0] base;
        biased = 17'h00000;
        base = 16'h0000;
        conv1 = to_freq(avg[0], ctrl.in_type[1], fmax);
        conv2 = to_freq(avg[1], ctrl.in_type[0], fmax);
        base = ctrl.bias_target ? scaled1 : keypad_potentiometer;
        next_freq_cmd = scaled1;
        next_pid = scaled2;
        if (ctrl.ai2_func) begin
            biased = 17'(base) + 17'(conv2);
            next_freq_cmd = (biased > 17'(fmax)) ? fmax : biased[15:0];
            next_pid = 16'h0000;
        end
        case (ctrl.meter_src)
            scaling_pkg::SRC_OUT_FREQ: meter_norm = to_meter(sense.out_freq, fmax);
            scaling_pkg::SRC_FREQ_SET: meter_norm = to_meter(freq_cmd, fmax);
            scaling_pkg::SRC_OUT_VOLT: meter_norm = to_meter(16'(sense.out_volt), 16'(`ADC_FULL));
            scaling_pkg::SRC_DC_BUS: meter_norm = to_meter(16'(sense.dc_bus), 16'(`ADC_FULL));
            scaling_pkg::SRC_OUT_CURR: meter_norm = to_meter(16'(sense.out_curr), 16'(`ADC_FULL));
            default: meter_norm = 16'h0000;
        endcase
        next_meter = meter_scaled[11:0];
        next_preset_freq = freq_tab[preset_sel];
        if (ctrl.preset_mode) begin
            next_acc = ramp_scale(acc_tab[preset_sel], freq_tab[preset_sel], rated);
            next_dec = ramp_scale(dec_tab[preset_sel], freq_tab[preset_sel], rated);
        end else begin
            next_acc = ctrl.ramp_set ? ramp_common[2] : ramp_common[0];
            next_dec = ctrl.ramp_set ? ramp_common[3] : ramp_common[1];
        end
    end

    // output flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_cmd <= 16'h0000;
            pid_feedback <= 16'h0000;
            meter_out <= 12'h000;
            preset_freq <= 16'h0000;
            ramp_acc <= 16'h0000;
            ramp_dec <= 16'h0000;
        end else begin
            freq_cmd <= next_freq_cmd;
            pid_feedback <= next_pid;
            meter_out <= next_meter;
            preset_freq <= next_preset_freq;
            ramp_acc <= next_acc;
            ramp_dec <= next_dec;
        end
    end

    // ticks seen since the last average of the first input
    logic [8:0] ticks_seen;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ticks_seen <= 9'h000;
        end else if (upd[0] || scan_wr[0]) begin
            ticks_seen <= 9'h000;
        end else if (tick) begin
            ticks_seen <= ticks_seen + 9'h001;
        end
    end

    // checks
    property p_full_span;
        !ctrl.in_type[1] && avg[0] == `ADC_FULL |-> conv1 == fmax;
    endproperty
    a_full_span: assert property (p_full_span) else $error("full-span top code not fmax");
    property p_live_zero;
        ctrl.in_type[1] && avg[0] < `LIVE_ZERO |-> conv1 == 16'h0000;
    endproperty
    a_live_zero: assert property (p_live_zero) else $error("below live zero not zero");
    property p_scan_window;
        upd[0] |-> ticks_seen == 9'(scan_eff[0]);
    endproperty
    a_scan_window: assert property (p_scan_window) else $error("average window wrong");
    property p_bias_mode_pid;
        ctrl.ai2_func |=> pid_feedback == 16'h0000;
    endproperty
    a_bias_mode_pid: assert property (p_bias_mode_pid) else $error("feedback in bias mode");
    property p_meter_cap;
        meter_out <= `METER_FULL;
    endproperty
    a_meter_cap: assert property (p_meter_cap) else $error("meter above 10 V code");
    property p_common_ramp;
        $past(rst_n) && !ctrl.preset_mode && !ctrl.ramp_set
            |=> ramp_acc == $past(ramp_common[0]);
    endproperty
    a_common_ramp: assert property (p_common_ramp) else $error("common ramp not used");
    property p_preset_store;
        (wr && addr[7:6] == 2'b01 && addr[1:0] == 2'b00) ##1 (rd && addr == $past(addr))
            |=> rdata == ($past(wdata, 2) & 32'h0000FFFF);
    endproperty
    a_preset_store: assert property (p_preset_store) else $error("preset not stored");
    property p_ramp_at_rated;
        ctrl.preset_mode && rated != 16'h0000 && rated == freq_tab[preset_sel]
            |=> ramp_dec == $past(dec_tab[preset_sel]);
    endproperty
    a_ramp_at_rated: assert property (p_ramp_at_rated) else $error("ramp scaling wrong");
    property p_cmd_clamp;
        ##1 freq_cmd <= $past(fmax);
    endproperty
    a_cmd_clamp: assert property (p_cmd_clamp) else $error("command above fmax");
    c_live_clip: cover property (ctrl.in_type[1] && avg[0] < `LIVE_ZERO && avg[0] != 12'h000);
    c_bias_mode: cover property (ctrl.ai2_func && ctrl.bias_target ##1 freq_cmd != 16'h0000);
    c_preset_ramp: cover property (ctrl.preset_mode ##1 ramp_acc != 16'h0000);
    c_meter_full: cover property (meter_out == `METER_FULL);

endmodule : analog_ref_scaling_preset_speed

/* tb/analog_source.sv */
// source model: two analog generators feeding the converter codes
// assumes: bench sets the levels; codes change only on clk edges
`timescale 1ns/1ns
module analog_source (
    // clock
    input wire logic clk,
    // levels requested by the bench
    input wire logic [11:0] lvl_one,
    input wire logic [11:0] lvl_two,
    // converter codes seen by the block
    output logic [11:0] analog_in_one,
    output logic [11:0] analog_in_two
);
    // sources settle one edge after a new level
    always_ff @(posedge clk) begin
        analog_in_one <= lvl_one;
        analog_in_two <= lvl_two;
    end
endmodule : analog_source

/* tb/analog_ref_scaling_preset_speed_test.sv */
// bench for the analog scaling, meter and preset speed block
// assumes: package, map header, design and source model compiled first
`timescale 1ns/1ns
`include "scaling_map.svh"
module analog_ref_scaling_preset_speed_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [11:0] lvl_one = 12'h000;
    logic [11:0] lvl_two = 12'h000;
    logic [15:0] keypad = 16'h0000;
    logic [3:0] preset_sel = 4'h0;
    scaling_pkg::sense_t sense = '0;
    logic [31:0] rdata;
    logic [11:0] ain1, ain2, meter_out;
    logic [15:0] freq_cmd, pid_feedback, preset_freq, ramp_acc, ramp_dec;
    int errors = 0;
    int n_compared = 0;
    analog_source analog_source_i (.clk(clk), .lvl_one(lvl_one), .lvl_two(lvl_two),
        .analog_in_one(ain1), .analog_in_two(ain2));
    analog_ref_scaling_preset_speed #(.TICK_CYCLES(20)) analog_ref_scaling_preset_speed_i (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .analog_in_one(ain1), .analog_in_two(ain2),
        .keypad_potentiometer(keypad), .preset_sel(preset_sel), .sense(sense),
        .freq_cmd(freq_cmd), .pid_feedback(pid_feedback), .preset_freq(preset_freq),
        .ramp_acc(ramp_acc), .ramp_dec(ramp_dec), .meter_out(meter_out));
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask : rd_reg
    // write then read back in the next cycle, upper half must read zero
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", d & 32'h0000FFFF, rdata);
    endtask : wr_rd
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic wait_cmd(input logic [15:0] exp);
        int k;
        #1;
        for (k = 0; k < 400 && freq_cmd !== exp; k++) begin
            @(posedge clk);
            #1;
        end
        chk("freq_cmd", {16'h0, exp}, {16'h0, freq_cmd});
        if (k == 400) wrap_up();
    endtask : wait_cmd
    // reset values and refused addresses
    task automatic t_reset();
        rd_reg(`REG_FMAX, 32'h0000_1770);
        rd_reg(`REG_RATED, 32'h0000_1770);
        rd_reg(8'h3E, 32'h0);
        chk("ramp_acc", 32'h64, {16'h0, ramp_acc});
    endtask : t_reset
    // full span, live zero, bias and slope on input one
    task automatic t_analog();
        wr_reg(`REG_CTRL, 32'h0);
        wr_reg(`REG_AI1_SCAN, 32'h3);
        lvl_one <= 12'hFFF;
        lvl_two <= 12'hFFF;
        wait_cmd(16'h1770);
        chk("pid_feedback", 32'h1770, {16'h0, pid_feedback});
        rd_reg(`REG_STATUS, 32'h00FF_FFFF);
        wr_reg(`REG_CTRL, 32'h2);
        lvl_one <= 12'h200;
        wait_cmd(16'h0000);
        wr_reg(`REG_CTRL, 32'h0);
        wr_reg(`REG_AI1_BIAS, 32'h3E8);
        lvl_one <= 12'h000;
        wait_cmd(16'h1770);
        wr_reg(`REG_AI1_BIAS, 32'h800);
        lvl_one <= 12'hFFF;
        wait_cmd(16'h0000);
    endtask : t_analog
    // second input as bias on the keypad, then on input one
    task automatic t_bias();
        wr_reg(`REG_AI2_GAIN, 32'h0);
        keypad <= 16'h03E8;
        lvl_two <= 12'h800;
        wr_reg(`REG_CTRL, 32'h4);
        wait_cmd(16'h0FA0);
        chk("pid_feedback", 32'h0, {16'h0, pid_feedback});
        wr_reg(`REG_CTRL, 32'hC);
        wait_cmd(16'h0BB8);
    endtask : t_bias
    // preset table and both ramp modes
    task automatic t_preset();
        wr_rd(`REG_FREQ_BASE + 8'h0C, 32'hABCD0BB8);
        wr_reg(`REG_DEC_BASE + 8'h0C, 32'hC8);
        wr_reg(`REG_ACC2, 32'h123);
        wr_reg(`REG_CTRL, 32'h10);
        preset_sel <= 4'h3;
        settle();
        chk("preset_freq", 32'hBB8, {16'h0, preset_freq});
        chk("ramp_acc", 32'h32, {16'h0, ramp_acc});
        chk("ramp_dec", 32'h64, {16'h0, ramp_dec});
        wr_reg(`REG_RATED, 32'hBB8);
        settle();
        chk("ramp_dec", 32'hC8, {16'h0, ramp_dec});
        wr_reg(`REG_CTRL, 32'h20);
        settle();
        chk("ramp_acc", 32'h123, {16'h0, ramp_acc});
    endtask : t_preset
    // meter source, gain and ceiling
    task automatic t_meter();
        sense <= '{16'h0BB8, 12'h400, 12'hFFF, 12'hC00};
        wr_reg(`REG_CTRL, 32'hC0);
        settle();
        chk("meter_out", 32'hFA0, {20'h0, meter_out});
        wr_reg(`REG_CTRL, 32'h0);
        settle();
        chk("meter_out", 32'h7D0, {20'h0, meter_out});
        wr_reg(`REG_CTRL, 32'h80);
        settle();
        chk("meter_out", 32'h3E8, {20'h0, meter_out});
        wr_reg(`REG_CTRL, 32'h100);
        settle();
        chk("meter_out", 32'hBB8, {20'h0, meter_out});
        wr_reg(`REG_CTRL, 32'hC0);
        wr_reg(`REG_METER_GAIN, 32'h3E8);
        sense.dc_bus <= 12'h800;
        settle();
        chk("meter_out", 32'hFA0, {20'h0, meter_out});
        sense.dc_bus <= 12'h000;
        settle();
        chk("meter_out", 32'h0, {20'h0, meter_out});
        wr_reg(`REG_METER_BIAS, 32'h800);
        settle();
        chk("meter_out", 32'hFA0, {20'h0, meter_out});
    endtask : t_meter
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_analog();
        t_bias();
        t_preset();
        t_meter();
        wrap_up();
    end
endmodule : analog_ref_scaling_preset_speed_test
